// ### logic/hrpc_params.svh
/*
  Offsets, field positions, reset values and counts of the hibernation
  power controller. Assumes byte addressing on a 32-bit bus, one word per
  register.
*/
`ifndef HRPC_PARAMS_SVH
`define HRPC_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define HRPC_OFS_COUNT       12'h000
`define HRPC_OFS_MATCH0      12'h004
`define HRPC_OFS_MATCH1      12'h008
`define HRPC_OFS_LOAD        12'h00C
`define HRPC_OFS_CTRL        12'h010
`define HRPC_OFS_MASK        12'h014
`define HRPC_OFS_RAW         12'h018
`define HRPC_OFS_MASKED      12'h01C
`define HRPC_OFS_CLEAR       12'h020
`define HRPC_OFS_TRIM        12'h024
`define HRPC_OFS_MEM_FIRST   12'h030
`define HRPC_OFS_MEM_LAST    12'h12C

// ----------------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------------
`define HRPC_CTL_COUNTER_EN  0
`define HRPC_CTL_HIB_REQ     1
`define HRPC_CTL_CLK_SEL     2
`define HRPC_CTL_MATCH_WAKE  3
`define HRPC_CTL_PIN_WAKE    4
`define HRPC_CTL_LOW_BATTERY_FLAG_EN   5
`define HRPC_CTL_CLK_EN      6
`define HRPC_CTL_LOW_BATTERY_FLAG_ABT  7

// ----------------------------------------------------------------------
// event bits (raw, mask, masked, clear)
// ----------------------------------------------------------------------
`define HRPC_EV_MATCH0       0
`define HRPC_EV_MATCH1       1
`define HRPC_EV_LOW_BATTERY_FLAG       2
`define HRPC_EV_WAKE_PIN     3
`define HRPC_EV_WIDTH        4

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define HRPC_RST_MATCH       32'hFFFFFFFF
`define HRPC_RST_LOAD        32'hFFFFFFFF
`define HRPC_RST_TRIM        16'h7FFF
`define HRPC_NOMINAL_RELOAD  16'h7FFF
`define HRPC_XTAL_DIVIDE     128
`define HRPC_TRIM_PERIOD     64
`define HRPC_MEM_WORDS       64

`endif

// ### logic/hrpc_pkg.sv
/*
  Types of the hibernation power controller.
  Assumes hrpc_params.svh for the numeric constants.
*/
package hrpc_pkg;

  // control register fields, bit 0 first from the bottom
  typedef struct packed {
    logic low_battery_flag_abort;
    logic clock_source_enable;
    logic low_battery_detect_enable;
    logic pin_wake_enable;
    logic match_wake_enable;
    logic clock_source_select;
    logic hibernate_request;
    logic counter_enable;
  } hrpc_ctrl_type;

  typedef enum logic [1:0] {
    HRPC_ST_RUN = 2'b01,
    HRPC_ST_HIB = 2'b10
  } hrpc_state_type;

endpackage : hrpc_pkg

// ### logic/hrpc_top.sv
/*
  Hibernation power controller: seconds counter with trimmed predivider,
  two match comparators, 64-word retained memory, low-battery flag,
  regulator enable and wake logic, behind a classic Wishbone slave.
  Assumes the clock references, wake pin and battery comparator arrive
  synchronous to clk_sys, which runs well above the reference rate.
*/
`timescale 1ns/10ps
`include "hrpc_params.svh"

module hrpc_top #(
  parameter int MEM_WORDS = `HRPC_MEM_WORDS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        xtal_clock_in,
  input  wire logic        osc_clock_in,
  input  wire logic        battery_low_in,
  input  wire logic        wake_pin_n,
  output logic             regulator_enable_n,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  hrpc_pkg::hrpc_ctrl_type  ctrl;
  hrpc_pkg::hrpc_state_type state;
  logic [31:0] seconds;
  logic [31:0] match_zero_reg;
  logic [31:0] match_one_reg;
  logic [31:0] counter_load_reg;
  logic [15:0] predivider_trim_reg;
  logic [15:0] predivider;
  logic [6:0]  xtal_div;
  logic [`HRPC_EV_WIDTH-1:0] event_mask_reg;
  logic [`HRPC_EV_WIDTH-1:0] raw_event_status;
  logic [`HRPC_EV_WIDTH-1:0] masked_event_status;
  logic [`HRPC_EV_WIDTH-1:0] event_set;
  logic [`HRPC_EV_WIDTH-1:0] event_clr;
  logic [31:0] retained_memory_words [MEM_WORDS];
  logic        xtal_q;
  logic        osc_q;
  logic        ref_tick;
  logic        second_tick;
  logic        wake_meta;
  logic        wake_sync;
  logic        wake_sync_q;
  logic        eq0;
  logic        eq1;
  logic        eq0_q;
  logic        eq1_q;
  logic        low_battery_flag;
  logic        match_zero_event;
  logic        match_one_event;
  logic        wake_pin_event;
  logic        wake_now;
  logic        hib_go;
  logic        bus_req;
  logic        wr_stb;
  logic        mem_hit;
  logic [5:0]  mem_idx;
  logic [31:0] wmask;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb  = bus_req & wb_we_i;
  assign mem_hit = (wb_adr_i >= `HRPC_OFS_MEM_FIRST) && (wb_adr_i <= `HRPC_OFS_MEM_LAST)
                   && (wb_adr_i[1:0] == 2'h0);
  assign mem_idx = 6'(12'(wb_adr_i - `HRPC_OFS_MEM_FIRST) >> 2);
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ----------------------------------------------------------------------
  // reference clock: divided crystal or direct oscillator
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xtal_q <= 1'b0;
      osc_q  <= 1'b0;
    end else begin
      xtal_q <= xtal_clock_in;
      osc_q  <= osc_clock_in;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xtal_div <= 7'h00;
    end else if (ctrl.clock_source_enable && xtal_clock_in && !xtal_q) begin
      xtal_div <= xtal_div + 7'h01;
    end
  end

  // one tick per reference period; nothing ticks while the source is off
  always_comb begin
    ref_tick = 1'b0;
    if (ctrl.clock_source_enable) begin
      if (ctrl.clock_source_select) begin
        ref_tick = osc_clock_in & ~osc_q;
      end else begin
        ref_tick = xtal_clock_in & ~xtal_q & (xtal_div == 7'(`HRPC_XTAL_DIVIDE - 1));
      end
    end
  end

  // ----------------------------------------------------------------------
  // predivider and seconds counter
  // ----------------------------------------------------------------------
  assign second_tick = ctrl.counter_enable && ref_tick && (predivider == 16'h0000);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      predivider <= `HRPC_NOMINAL_RELOAD;
    end else if (ctrl.counter_enable && ref_tick) begin
      if (predivider == 16'h0000) begin
        // trim reload for the second that starts a 64-second group
        // full 16 bits, so a trim above nominal lengthens that second
        if (6'(seconds + 32'h1) == 6'(`HRPC_TRIM_PERIOD)) begin
          predivider <= predivider_trim_reg;
        end else begin
          predivider <= `HRPC_NOMINAL_RELOAD;
        end
      end else begin
        predivider <= predivider - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seconds <= 32'h00000000;
    end else if (wr_stb && wb_adr_i == `HRPC_OFS_LOAD) begin
      seconds <= (seconds & ~wmask) | (wb_dat_i & wmask);
    end else if (second_tick) begin
      seconds <= seconds + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------------
  // match comparators
  // ----------------------------------------------------------------------
  assign eq0 = (seconds == match_zero_reg);
  assign eq1 = (seconds == match_one_reg);
  assign match_zero_event = eq0 & ~eq0_q;
  assign match_one_event  = eq1 & ~eq1_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      eq0_q <= 1'b1;
      eq1_q <= 1'b1;
    end else begin
      eq0_q <= eq0;
      eq1_q <= eq1;
    end
  end

  // ----------------------------------------------------------------------
  // wake pin synchroniser and battery monitor
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_meta   <= 1'b0;
      wake_sync   <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta   <= ~wake_pin_n;
      wake_sync   <= wake_meta;
      wake_sync_q <= wake_sync;
    end
  end

  assign wake_pin_event = wake_sync & ~wake_sync_q;

  // battery is not measured while hibernating
  assign low_battery_flag = ctrl.low_battery_detect_enable && battery_low_in
                            && (state == hrpc_pkg::HRPC_ST_RUN);

  // ----------------------------------------------------------------------
  // event flags: set wins over clear
  // ----------------------------------------------------------------------
  always_comb begin
    event_set = '0;
    event_set[`HRPC_EV_MATCH0]   = match_zero_event;
    event_set[`HRPC_EV_MATCH1]   = match_one_event;
    event_set[`HRPC_EV_LOW_BATTERY_FLAG]   = low_battery_flag;
    event_set[`HRPC_EV_WAKE_PIN] = wake_pin_event;
  end

  assign event_clr = (wr_stb && wb_adr_i == `HRPC_OFS_CLEAR && wb_sel_i[0])
                     ? wb_dat_i[`HRPC_EV_WIDTH-1:0] : '0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      raw_event_status <= '0;
    end else begin
      raw_event_status <= (raw_event_status & ~event_clr) | event_set;
    end
  end

  assign masked_event_status = raw_event_status & event_mask_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |masked_event_status;
    end
  end

  // ----------------------------------------------------------------------
  // hibernation state and regulator enable
  // ----------------------------------------------------------------------
  assign hib_go = wr_stb && (wb_adr_i == `HRPC_OFS_CTRL) && wb_sel_i[0]
                  && wb_dat_i[`HRPC_CTL_HIB_REQ]
                  && !(wb_dat_i[`HRPC_CTL_LOW_BATTERY_FLAG_ABT] && raw_event_status[`HRPC_EV_LOW_BATTERY_FLAG]);
  assign wake_now = (ctrl.pin_wake_enable && wake_pin_event)
                    || (ctrl.match_wake_enable && (match_zero_event || match_one_event));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= hrpc_pkg::HRPC_ST_RUN;
    end else begin
      case (state)
        hrpc_pkg::HRPC_ST_RUN: begin
          if (hib_go) begin
            state <= hrpc_pkg::HRPC_ST_HIB;
          end
        end
        hrpc_pkg::HRPC_ST_HIB: begin
          if (wake_now) begin
            state <= hrpc_pkg::HRPC_ST_RUN;
          end
        end
        default: begin
          state <= hrpc_pkg::HRPC_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regulator_enable_n <= 1'b1;
    end else if (state == hrpc_pkg::HRPC_ST_RUN && hib_go) begin
      regulator_enable_n <= 1'b0;
    end else if (state == hrpc_pkg::HRPC_ST_HIB && wake_now) begin
      regulator_enable_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
    end else if (wr_stb && wb_adr_i == `HRPC_OFS_CTRL && wb_sel_i[0]) begin
      ctrl <= hrpc_pkg::hrpc_ctrl_type'(wb_dat_i[7:0]);
      ctrl.hibernate_request <= hib_go;
    end else if (state == hrpc_pkg::HRPC_ST_HIB && wake_now) begin
      ctrl.hibernate_request <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      match_zero_reg      <= `HRPC_RST_MATCH;
      match_one_reg       <= `HRPC_RST_MATCH;
      counter_load_reg    <= `HRPC_RST_LOAD;
      predivider_trim_reg <= `HRPC_RST_TRIM;
      event_mask_reg      <= '0;
    end else if (wr_stb) begin
      case (wb_adr_i)
        `HRPC_OFS_MATCH0: match_zero_reg <= (match_zero_reg & ~wmask) | (wb_dat_i & wmask);
        `HRPC_OFS_MATCH1: match_one_reg <= (match_one_reg & ~wmask) | (wb_dat_i & wmask);
        `HRPC_OFS_LOAD:   counter_load_reg <= (counter_load_reg & ~wmask) | (wb_dat_i & wmask);
        `HRPC_OFS_TRIM:   predivider_trim_reg <= (predivider_trim_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        `HRPC_OFS_MASK: begin
          if (wb_sel_i[0]) begin
            event_mask_reg <= wb_dat_i[`HRPC_EV_WIDTH-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // retained memory: no reset so contents survive power cut
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (wr_stb && mem_hit) begin
      retained_memory_words[mem_idx] <= (retained_memory_words[mem_idx] & ~wmask) | (wb_dat_i & wmask);
    end
  end

  // ----------------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    if (mem_hit) begin
      next_rdata = retained_memory_words[mem_idx];
    end else begin
      case (wb_adr_i)
        `HRPC_OFS_COUNT:  next_rdata = seconds;
        `HRPC_OFS_MATCH0: next_rdata = match_zero_reg;
        `HRPC_OFS_MATCH1: next_rdata = match_one_reg;
        `HRPC_OFS_LOAD:   next_rdata = counter_load_reg;
        `HRPC_OFS_CTRL:   next_rdata = {24'h000000, ctrl};
        `HRPC_OFS_MASK:   next_rdata = {28'h0000000, event_mask_reg};
        `HRPC_OFS_RAW:    next_rdata = {28'h0000000, raw_event_status};
        `HRPC_OFS_MASKED: next_rdata = {28'h0000000, masked_event_status};
        `HRPC_OFS_TRIM:   next_rdata = {16'h0000, predivider_trim_reg};
        default:          next_rdata = 32'h00000000;
      endcase
    end
  end

  // every access, reads included, answers in one cycle; a held request is acknowledged every other cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule : hrpc_top

// ### verif/hrpc_top_asserts.sv
/*
  Port-level checks of the hibernation power controller.
  Assumes a classic Wishbone master and the offsets of hrpc_params.svh.
*/
`timescale 1ns/10ps
`include "hrpc_params.svh"

module hrpc_checker #(
  parameter int MEM_WORDS = 64
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        xtal_clock_in,
  input wire logic        osc_clock_in,
  input wire logic        battery_low_in,
  input wire logic        wake_pin_n,
  input wire logic        regulator_enable_n,
  input wire logic        irq
);
  // ----------------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------------
  logic       req;
  logic       wr_taken;
  logic       ctrl_taken;
  logic [3:0] since_ctrl;

  assign req        = wb_cyc_i && wb_stb_i;
  assign wr_taken   = req && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign ctrl_taken = wr_taken && (wb_adr_i == `HRPC_OFS_CTRL);

  // cycles since the last control write, saturating
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      since_ctrl <= 4'hF;
    end else if (ctrl_taken) begin
      since_ctrl <= 4'h0;
    end else if (since_ctrl != 4'hF) begin
      since_ctrl <= since_ctrl + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  ack_follows_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("acknowledge without request");
  rdata_hold_a: assert property (!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o))
    else $error("read data changed outside a read");
  hib_enter_a: assert property (ctrl_taken && wb_dat_i[1] && !wb_dat_i[7] && regulator_enable_n
    |-> ##[1:4] !regulator_enable_n)
    else $error("hibernate request did not cut the regulator");
  hib_cause_a: assert property ($fell(regulator_enable_n) |-> since_ctrl <= 4'h5)
    else $error("regulator cut without a control write");
  irq_masked_a: assert property (wr_taken && wb_adr_i == `HRPC_OFS_MASK && wb_dat_i[3:0] == 4'h0
    |-> ##4 !irq)
    else $error("interrupt raised with all events masked");
  reset_state_a: assert property ($fell(rst) |-> regulator_enable_n && !irq && !wb_ack_o)
    else $error("outputs wrong after reset");
endmodule : hrpc_checker

bind hrpc_top hrpc_checker #(.MEM_WORDS(MEM_WORDS)) checker_inst (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .xtal_clock_in(xtal_clock_in), .osc_clock_in(osc_clock_in),
  .battery_low_in(battery_low_in), .wake_pin_n(wake_pin_n),
  .regulator_enable_n(regulator_enable_n), .irq(irq)
);

// ### verif/hrpc_far_side.sv
/*
  Far side model: free-running references, pulled-up wake pin, regulator.
  Assumes the bench asks for wake presses through press_wake.
*/
`timescale 1ns/10ps

module hrpc_far_side (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic press_wake,
  input  wire logic regulator_enable_n,
  output logic      osc_clock_in,
  output logic      xtal_clock_in,
  output logic      wake_pin_n,
  output logic      main_power_on
);
  // references are supplied whether or not the counter is used
  always @(posedge clk_sys) begin
    if (rst) begin
      osc_clock_in  <= 1'b0;
      xtal_clock_in <= 1'b1;
    end else begin
      osc_clock_in  <= !osc_clock_in;
      xtal_clock_in <= !xtal_clock_in;
    end
  end

  // pull-up holds the pin high unless pressed
  assign wake_pin_n = !press_wake;

  // regulator powers the main chip while its enable is high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      main_power_on <= 1'b1;
    end else begin
      main_power_on <= regulator_enable_n;
    end
  end
endmodule : hrpc_far_side

// ### verif/test_hibernation_rtc_power_control.sv
/*
  Self-checking bench of the hibernation power controller.
  Assumes hrpc_top, hrpc_far_side and the bound checker.
*/
`timescale 1ns/10ps
`include "hrpc_params.svh"

module test_hibernation_rtc_power_control;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [11:0] wb_adr  = 12'h000;
  logic [31:0] wb_dat  = 32'h00000000;
  logic        battery_low = 1'b0;
  logic        press_wake  = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        osc_clk;
  logic        xtal_clk;
  logic        wake_n;
  logic        reg_en_n;
  logic        irq;
  logic        power_on;
  logic [31:0] q;
  int          miscompares = 0;
  int          checks = 0;

  localparam logic [11:0] RST_OFS [0:10] = '{`HRPC_OFS_COUNT, `HRPC_OFS_MATCH0, `HRPC_OFS_MATCH1,
    `HRPC_OFS_LOAD, `HRPC_OFS_CTRL, `HRPC_OFS_MASK, `HRPC_OFS_RAW, `HRPC_OFS_MASKED,
    `HRPC_OFS_CLEAR, `HRPC_OFS_TRIM, 12'h028};
  localparam logic [31:0] RST_VAL [0:10] = '{32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00007FFF, 32'h0};

  always #12.5 clk_sys = !clk_sys;

  hrpc_top uut (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .xtal_clock_in(xtal_clk), .osc_clock_in(osc_clk), .battery_low_in(battery_low),
    .wake_pin_n(wake_n), .regulator_enable_n(reg_en_n), .irq(irq)
  );

  hrpc_far_side far_side (
    .clk_sys(clk_sys), .rst(rst), .press_wake(press_wake), .regulator_enable_n(reg_en_n),
    .osc_clock_in(osc_clk), .xtal_clock_in(xtal_clk), .wake_pin_n(wake_n), .main_power_on(power_on)
  );

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wb_access(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= wr;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    check({31'h0, wb_ack_o}, 32'h1);
    q = wb_dat_o;
    // the idle cycle after each access separates it from the next request
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb_access

  task automatic read_check(input logic [11:0] a, input logic [31:0] exp);
    wb_access(1'b0, a, 32'h0);
    check(q, exp);
  endtask : read_check

  task automatic wait_power(input logic lvl, input int lim);
    int n;
    n = 0;
    while (power_on !== lvl && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    check({31'h0, power_on}, {31'h0, lvl});
  endtask : wait_power

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset_values();
    wb_access(1'b1, `HRPC_OFS_COUNT, 32'h5A5A5A5A);
    wb_access(1'b1, 12'h028, 32'h12345678);
    for (int i = 0; i < 11; i++) begin
      read_check(RST_OFS[i], RST_VAL[i]);
    end
  endtask : test_reset_values

  task automatic test_memory();
    logic [11:0] w [0:2] = '{12'h030, 12'h034, 12'h12C};
    for (int i = 0; i < 3; i++) begin
      wb_access(1'b1, w[i], 32'hA5C30000 | i);
    end
    for (int i = 0; i < 3; i++) begin
      read_check(w[i], 32'hA5C30000 | i);
    end
  endtask : test_memory

  task automatic test_match();
    for (int m = 0; m < 2; m++) begin
      wb_access(1'b1, `HRPC_OFS_MASK, 32'h0);
      wb_access(1'b1, `HRPC_OFS_MATCH0 + 12'(4 * m), 32'h100 + m);
      wb_access(1'b1, `HRPC_OFS_LOAD, 32'h100 + m);
      read_check(`HRPC_OFS_RAW, 32'h1 << m);
      check({31'h0, irq}, 32'h0);
      wb_access(1'b1, `HRPC_OFS_MASK, 32'h1 << m);
      repeat (4) @(posedge clk_sys);
      check({31'h0, irq}, 32'h1);
      read_check(`HRPC_OFS_MASKED, 32'h1 << m);
      wb_access(1'b1, `HRPC_OFS_CLEAR, 32'h1 << m);
      read_check(`HRPC_OFS_RAW, 32'h0);
      repeat (4) @(posedge clk_sys);
      check({31'h0, irq}, 32'h0);
    end
  endtask : test_match

  task automatic test_low_battery_flag();
    battery_low <= 1'b1;
    wb_access(1'b1, `HRPC_OFS_CTRL, 32'h40);
    repeat (8) @(posedge clk_sys);
    read_check(`HRPC_OFS_RAW, 32'h0);
    wb_access(1'b1, `HRPC_OFS_CTRL, 32'h60);
    read_check(`HRPC_OFS_RAW, 32'h4);
    wb_access(1'b1, `HRPC_OFS_CTRL, 32'hF2);
    repeat (6) @(posedge clk_sys);
    check({31'h0, power_on}, 32'h1);
    read_check(`HRPC_OFS_CTRL, 32'hF0);
    battery_low <= 1'b0;
    wb_access(1'b1, `HRPC_OFS_CLEAR, 32'h4);
    read_check(`HRPC_OFS_RAW, 32'h0);
  endtask : test_low_battery_flag

  task automatic test_pin_wake();
    wb_access(1'b1, `HRPC_OFS_CTRL, 32'h56);
    wait_power(1'b0, 10);
    press_wake <= 1'b1;
    wait_power(1'b1, 20);
    press_wake <= 1'b0;
    read_check(`HRPC_OFS_RAW, 32'h8);
    read_check(`HRPC_OFS_CTRL, 32'h54);
    wb_access(1'b1, `HRPC_OFS_CLEAR, 32'hF);
  endtask : test_pin_wake

  task automatic test_match_wake();
    wb_access(1'b1, `HRPC_OFS_MATCH0, 32'h200);
    wb_access(1'b1, `HRPC_OFS_CTRL, 32'h4E);
    wait_power(1'b0, 10);
    press_wake <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check({31'h0, power_on}, 32'h0);
    press_wake <= 1'b0;
    wb_access(1'b1, `HRPC_OFS_LOAD, 32'h200);
    wait_power(1'b1, 10);
    wb_access(1'b0, `HRPC_OFS_RAW, 32'h0);
    check(q & 32'h1, 32'h1);
    wb_access(1'b1, `HRPC_OFS_CLEAR, 32'hF);
  endtask : test_match_wake

  task automatic test_trim();
    int n;
    n = 0;
    wb_access(1'b1, `HRPC_OFS_TRIM, 32'h3);
    wb_access(1'b1, `HRPC_OFS_LOAD, 32'h3F);
    wb_access(1'b1, `HRPC_OFS_CTRL, 32'h45);
    q = 32'h3F;
    while (q == 32'h3F && n < 30000) begin
      wb_access(1'b0, `HRPC_OFS_COUNT, 32'h0);
      n++;
    end
    check(q, 32'h40);
    repeat (12) @(posedge clk_sys);
    read_check(`HRPC_OFS_COUNT, 32'h41);
    repeat (200) @(posedge clk_sys);
    read_check(`HRPC_OFS_COUNT, 32'h41);
  endtask : test_trim

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset_values();
    test_memory();
    test_match();
    test_low_battery_flag();
    test_pin_wake();
    test_match_wake();
    test_trim();
    give_verdict();
  end

  initial begin
    #2500000;
    miscompares++;
    give_verdict();
  end
endmodule : test_hibernation_rtc_power_control
